// *** dsa_seq.sv ***
// sequencer, result latches and byte port of the dual-slope converter
//
// Operation
// - gate high: conversions repeat, each cycle 8192 clocks long
// - integrate lasts 2048 clocks; polarity captured as sign at its end
// - deintegrate counts clocks until comparator zero crossing; count is magnitude
// - low 12 bits of the 13-bit counter feed latches driving three-state outputs with sign, overrange
// - integrator-clear only after overrange, ending within 1024 clocks
// - clear phase: inputs off, reference charged, comparator fed to buffer
// - status rises at integrate start, falls on the same edge as the latch write
// - latched data never changes while status is low
// - mode select low means direct mode via chip and byte selects
// - mode pulse high triggers one single-clock handshake request pulse then back to direct
// - mode held high gives handshake output after every conversion
// - gate high: continuous conversion, latches updated after zero crossing
// - gate low after zero crossing skips rest of deintegrate to auto-zero
// - gate low: finish, minimum auto-zero, then hold until gate high
// - gate rising in hold: status and integrate follow 11 clocks later, 7 of them in resume
// - chip and byte selects are active low, idle high
// - chip select low with byte select low enables that byte
// - low byte magnitude bits 1-8; high byte bits 9-12, sign, overrange
`timescale 1ns/1ps
`include "dsa_defines.svh"
module dsa_seq (
  input wire logic clock,
  input wire logic rst,
  input wire logic conversion_gate,
  input wire logic comparator_pos,
  input wire logic output_mode_select,
  input wire logic chip_select_n,
  input wire logic low_byte_select_n,
  input wire logic high_byte_select_n,
  output logic status_flag,
  output logic zeroing_phase,
  output logic integrate_phase,
  output logic deintegrate_phase,
  output logic integrator_clear_phase,
  output logic handshake_request,
  output logic [7:0] data_out,
  output logic [7:0] data_oe
);
  // ==========================================================
  // input synchronisers
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [1:0] byte_sync1;
  logic [1:0] byte_sync2;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // chip select starts at its idle high level, so reset shows no false select
      sync1 <= 5'h02;
      sync2 <= 5'h02;
      byte_sync1 <= 2'h3;
      byte_sync2 <= 2'h3;
    end else begin
      sync1 <= {conversion_gate, comparator_pos, output_mode_select, chip_select_n, 1'b0};
      sync2 <= sync1;
      byte_sync1 <= {high_byte_select_n, low_byte_select_n};
      byte_sync2 <= byte_sync1;
    end
  end
  logic gate;
  logic comp;
  logic mode;
  logic cs_n;
  assign gate = sync2[4];
  assign comp = sync2[3];
  assign mode = sync2[2];
  assign cs_n = sync2[1];
  logic mode_prev;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) mode_prev <= 1'b0;
    else mode_prev <= mode;
  end

  // ==========================================================
  // phase sequencer
  localparam logic [12:0] ZERO_MIN = 13'(`DSA_CYCLE_CLKS - `DSA_INT_CLKS - `DSA_DE_CLKS - `DSA_ZI_MAX_CLKS);
  // without a clear phase, zeroing takes its slot so the cycle stays the same length
  localparam logic [12:0] ZERO_FULL = 13'(`DSA_CYCLE_CLKS - `DSA_INT_CLKS - `DSA_DE_CLKS);
  dsa_pkg::dsa_phase_t phase;
  logic [12:0] count;
  logic crossed;
  dsa_pkg::dsa_result_t result;
  logic latch_now;
  logic ovr_now;
  logic sign_now;
  logic after_clear;

  // full scale reached without a crossing
  assign ovr_now = (phase == dsa_pkg::dsa_deint) && !crossed && (count == 13'(`DSA_DE_CLKS - 1));
  // crossing: comparator leaves the captured polarity; write once
  assign latch_now = (phase == dsa_pkg::dsa_deint) && !crossed && (comp != sign_now || ovr_now);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= dsa_pkg::dsa_zero;
      count <= 13'h0000;
      crossed <= 1'b0;
      after_clear <= 1'b0;
    end else begin
      count <= count + 13'h0001;
      case (phase)
        dsa_pkg::dsa_zero: begin
          // minimum auto-zero after a clear or when holding, else full slot
          if ((count == ZERO_MIN - 13'h0001 && (after_clear || !gate)) || count == ZERO_FULL - 13'h0001) begin
            count <= 13'h0000;
            after_clear <= 1'b0;
            phase <= gate ? dsa_pkg::dsa_int : dsa_pkg::dsa_wait;
          end
        end
        dsa_pkg::dsa_wait: begin
          count <= 13'h0000;
          if (gate) phase <= dsa_pkg::dsa_resume;
        end
        dsa_pkg::dsa_resume: begin
          if (count == 13'(`DSA_RESUME_CLKS - 1)) begin
            count <= 13'h0000;
            phase <= dsa_pkg::dsa_int;
          end
        end
        dsa_pkg::dsa_int: begin
          if (count == 13'(`DSA_INT_CLKS - 1)) begin
            count <= 13'h0000;
            crossed <= 1'b0;
            phase <= dsa_pkg::dsa_deint;
          end
        end
        dsa_pkg::dsa_deint: begin
          if (latch_now) crossed <= 1'b1;
          if (ovr_now) begin
            count <= 13'h0000;
            after_clear <= 1'b1;
            phase <= dsa_pkg::dsa_clear;
          end else if (count == 13'(`DSA_DE_CLKS - 1) || (crossed && !gate)) begin
            // gate low after the crossing cuts deintegrate short
            count <= 13'h0000;
            phase <= dsa_pkg::dsa_zero;
          end
        end
        dsa_pkg::dsa_clear: begin
          // integrator driven to zero; bounded length
          if (count == 13'(`DSA_ZI_MAX_CLKS - 1)) begin
            count <= 13'h0000;
            phase <= dsa_pkg::dsa_zero;
          end
        end
        default: begin
          count <= 13'h0000;
          phase <= dsa_pkg::dsa_zero;
        end
      endcase
    end
  end

  // phase outputs drive the analog switches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zeroing_phase <= 1'b1;
      integrate_phase <= 1'b0;
      deintegrate_phase <= 1'b0;
      integrator_clear_phase <= 1'b0;
    end else begin
      zeroing_phase <= phase == dsa_pkg::dsa_zero || phase == dsa_pkg::dsa_wait || phase == dsa_pkg::dsa_resume;
      integrate_phase <= phase == dsa_pkg::dsa_int;
      deintegrate_phase <= phase == dsa_pkg::dsa_deint;
      integrator_clear_phase <= phase == dsa_pkg::dsa_clear;
    end
  end

  // ==========================================================
  // handshake trigger, blocks latch updates while pending
  logic hs_pending;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) hs_pending <= 1'b0;
    else if (mode && !mode_prev) hs_pending <= 1'b1;
    else if (latch_now && mode) hs_pending <= 1'b1;
    else if (hs_pending && handshake_request) hs_pending <= 1'b0;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) handshake_request <= 1'b0;
    else handshake_request <= hs_pending && !handshake_request;
  end

  // ==========================================================
  // result latches, sign and status
  // polarity held aside until the latch write, so the outputs never mix two conversions
  always_ff @(posedge clock or posedge rst) begin
    if (rst) sign_now <= 1'b0;
    else if (phase == dsa_pkg::dsa_int && count == 13'(`DSA_INT_CLKS - 1)) sign_now <= comp;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) result <= '0;
    else if (latch_now && status_flag && !hs_pending) begin
      result.sign_bit <= sign_now;
      result.magnitude_bits <= count[11:0];
      result.ovr <= ovr_now;
    end
  end
  function automatic logic next_int_start(input dsa_pkg::dsa_phase_t p, input logic g);
    next_int_start = (p == dsa_pkg::dsa_resume) && g;
  endfunction : next_int_start
  // falls on the write edge itself; no half-clock edge exists in one clock domain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) status_flag <= 1'b0;
    else if (phase != dsa_pkg::dsa_int && count == 13'h0000 && next_int_start(phase, gate)) status_flag <= status_flag;
    else if (latch_now) status_flag <= 1'b0;
    else if (phase == dsa_pkg::dsa_int) status_flag <= 1'b1;
  end

  // ==========================================================
  // direct-mode byte port
  logic direct;
  assign direct = !mode && !hs_pending;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 8'h00;
    end else if (direct && !cs_n && !byte_sync2[0]) begin
      data_out <= result.magnitude_bits[7:0];
      data_oe <= 8'hff;
    end else if (direct && !cs_n && !byte_sync2[1]) begin
      data_out <= {2'h0, result.ovr, result.sign_bit, result.magnitude_bits[11:8]};
      data_oe <= 8'h3f;
    end else begin
      data_out <= 8'h00;
      data_oe <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  // helper counters: long spans are counted here rather than unrolled in properties
  logic [12:0] int_len;
  logic [12:0] clear_len;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_len <= 13'h0000;
      clear_len <= 13'h0000;
    end else begin
      int_len <= integrate_phase ? int_len + 13'h0001 : 13'h0000;
      clear_len <= integrator_clear_phase ? clear_len + 13'h0001 : 13'h0000;
    end
  end
  chk_int_length: assert property (@(posedge clock) disable iff (rst)
    $fell(integrate_phase) |-> int_len == 13'(`DSA_INT_CLKS))
    else $error("integrate length wrong");
  chk_clear_entry: assert property (@(posedge clock) disable iff (rst)
    $rose(integrator_clear_phase) |-> $past(ovr_now, 2))
    else $error("clear without overrange");
  chk_clear_bound: assert property (@(posedge clock) disable iff (rst)
    integrator_clear_phase |-> clear_len < 13'(`DSA_ZI_MAX_CLKS))
    else $error("clear too long");
  chk_hold_data: assert property (@(posedge clock) disable iff (rst)
    !status_flag && !$past(latch_now) |-> $stable(result))
    else $error("data changed while status low");
  chk_status_fall: assert property (@(posedge clock) disable iff (rst)
    latch_now && status_flag |=> !status_flag)
    else $error("status did not fall");
  chk_resume_delay: assert property (@(posedge clock) disable iff (rst)
    phase == dsa_pkg::dsa_wait && gate |=> ##7 phase == dsa_pkg::dsa_int)
    else $error("resume delay wrong");
  chk_skip_deint: assert property (@(posedge clock) disable iff (rst)
    phase == dsa_pkg::dsa_deint && crossed && !gate && !ovr_now |=> phase == dsa_pkg::dsa_zero)
    else $error("deintegrate not cut short");
  chk_byte_enable: assert property (@(posedge clock) disable iff (rst)
    data_oe != 8'h00 |-> $past(!cs_n && direct))
    else $error("byte driven without select");
  cov_overrange: cover property (@(posedge clock) disable iff (rst) $rose(integrator_clear_phase));
  cov_hold: cover property (@(posedge clock) disable iff (rst) phase == dsa_pkg::dsa_wait ##1 gate);
  cov_read_low: cover property (@(posedge clock) disable iff (rst) data_oe == 8'hff);
endmodule : dsa_seq

// *** dsa_defines.svh ***
// timing counts and field positions of the dual-slope sequencer
`ifndef DSA_DEFINES_SVH
`define DSA_DEFINES_SVH
// ==========================================================
// clock and phase lengths
`define DSA_CLK_NS 40
`define DSA_CYCLE_CLKS 8192
`define DSA_INT_CLKS 2048
`define DSA_DE_CLKS 4096
`define DSA_ZI_MAX_CLKS 1024
`define DSA_RESUME_CLKS 7
// ==========================================================
// high byte layout
`define DSA_HI_SIGN 4
`define DSA_HI_OVR 5
`endif

// *** dsa_pkg.sv ***
// types of the dual-slope sequencer
package dsa_pkg;
  // ==========================================================
  // phases
  typedef enum logic [2:0] {dsa_zero, dsa_wait, dsa_resume, dsa_int, dsa_deint, dsa_clear} dsa_phase_t;
  // latched result
  typedef struct packed {
    logic ovr;
    logic sign_bit;
    logic [11:0] magnitude_bits;
  } dsa_result_t;
endpackage : dsa_pkg

// *** dsa_host.sv ***
// host model that reads result bytes over the direct port
`timescale 1ns/1ps
module dsa_host (
  input wire logic clock,
  input wire logic status_flag,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  output logic chip_select_n,
  output logic low_byte_select_n,
  output logic high_byte_select_n
);
  // ==========================================================
  // no receiver-ready line here: direct reads assume it is held high
  // selects rest high, as open pins with pull-ups would
  initial begin
    chip_select_n = 1'b1;
    low_byte_select_n = 1'b1;
    high_byte_select_n = 1'b1;
  end
  // one read; waits for status low so latches are not mid-update
  task automatic rd(input logic cs, input logic hi, output logic [7:0] d, output logic [7:0] oe);
    int n;
    n = 0;
    @(negedge clock);
    while (status_flag !== 1'b0 && n < 9000) begin
      @(negedge clock);
      n++;
    end
    chip_select_n = ~cs;
    low_byte_select_n = hi;
    high_byte_select_n = ~hi;
    repeat (4) @(negedge clock);
    d = data_out;
    oe = data_oe;
    chip_select_n = 1'b1;
    low_byte_select_n = 1'b1;
    high_byte_select_n = 1'b1;
  endtask : rd
endmodule : dsa_host

// *** dsa_seq_tb_top.sv ***
// self-checking bench of the dual-slope sequencer
`timescale 1ns/1ps
module dsa_seq_tb_top;
  logic clock, rst, conversion_gate, comparator_pos, output_mode_select;
  logic chip_select_n, low_byte_select_n, high_byte_select_n;
  logic status_flag, zeroing_phase, integrate_phase, deintegrate_phase;
  logic integrator_clear_phase, handshake_request, sgn, int_q;
  logic [7:0] data_out, data_oe;
  int err_total, cmp_count, cross_n, dcnt, cyc, per, zi;
  dsa_seq dut (.clock(clock), .rst(rst), .conversion_gate(conversion_gate),
    .comparator_pos(comparator_pos), .output_mode_select(output_mode_select),
    .chip_select_n(chip_select_n), .low_byte_select_n(low_byte_select_n),
    .high_byte_select_n(high_byte_select_n), .status_flag(status_flag),
    .zeroing_phase(zeroing_phase), .integrate_phase(integrate_phase),
    .deintegrate_phase(deintegrate_phase), .integrator_clear_phase(integrator_clear_phase),
    .handshake_request(handshake_request), .data_out(data_out), .data_oe(data_oe));
  dsa_host host (.clock(clock), .status_flag(status_flag), .data_out(data_out), .data_oe(data_oe),
    .chip_select_n(chip_select_n), .low_byte_select_n(low_byte_select_n),
    .high_byte_select_n(high_byte_select_n));
  // ==========================================================
  // clock, comparator model and phase monitors
  always #20 clock = ~clock;
  // comparator keeps the sign through integrate and deintegrate until cross_n clocks pass
  always @(negedge clock) begin
    dcnt <= (deintegrate_phase === 1'b1) ? dcnt + 1 : 0;
    comparator_pos <= (integrate_phase === 1'b1 || (deintegrate_phase === 1'b1 && dcnt < cross_n)) ? sgn : ~sgn;
    int_q <= integrate_phase;
    cyc <= (integrate_phase && !int_q) ? 1 : cyc + 1;
    if (integrate_phase && !int_q) per <= cyc;
    if (integrator_clear_phase === 1'b1) zi <= zi + 1;
  end
  function automatic logic sig(input int w);
    case (w)
      0: return status_flag;
      1: return integrate_phase;
      2: return deintegrate_phase;
      3: return integrator_clear_phase;
      default: return handshake_request;
    endcase
  endfunction : sig
  // bounded wait for a level on one output
  task automatic wt(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    // a wait that runs out counts as a mismatch
    if (n >= lim) err_total++;
  endtask : wt
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // ==========================================================
  // scenarios
  task automatic t_conv;
    int n, z0;
    logic [7:0] d, oe;
    z0 = zi;
    check(data_oe, 8'h00);
    wt(1, 1, 20000, n);
    check(status_flag, 1'b1);
    wt(1, 0, 3000, n);
    check(n, 2048);
    host.rd(1'b1, 1'b0, d, oe);
    check({oe, d[7:4]}, {8'hff, 4'h0});
    host.rd(1'b1, 1'b1, d, oe);
    check({oe, d}, {8'h3f, 3'h0, sgn, 4'h5});
    host.rd(1'b0, 1'b0, d, oe);
    check(oe, 8'h00);
    wt(1, 1, 9000, n);
    @(negedge clock);
    check(per, 8192);
    check(zi - z0, 0);
    $display("test conv done");
  endtask : t_conv
  task automatic t_ovr;
    int n;
    logic [7:0] d, oe;
    sgn = 1'b0;
    cross_n = 99999;
    wt(0, 0, 7000, n);
    wt(3, 1, 300, n);
    wt(3, 0, 1100, n);
    check(n <= 1024 && n > 0, 1'b1);
    host.rd(1'b1, 1'b1, d, oe);
    check(d[5:4], 2'b10);
    sgn = 1'b1;
    cross_n = 12'h504;
    $display("test overrange done");
  endtask : t_ovr
  task automatic t_hold;
    int n;
    logic [7:0] d0, d1, oe;
    wt(0, 1, 9000, n);
    wt(0, 0, 7000, n);
    conversion_gate = 1'b0; // dropped after the crossing
    repeat (8) @(negedge clock);
    check(deintegrate_phase, 1'b0);
    host.rd(1'b1, 1'b1, d0, oe);
    repeat (3000) @(negedge clock);
    check({zeroing_phase, integrate_phase}, 2'b10);
    host.rd(1'b1, 1'b1, d1, oe);
    check(d1, d0);
    conversion_gate = 1'b1;
    wt(0, 1, 40, n);
    check(n >= 7 && n <= 11, 1'b1);
    $display("test hold done");
  endtask : t_hold
  task automatic t_mode;
    int n;
    logic [7:0] d, oe;
    output_mode_select = 1'b1;
    repeat (2) @(negedge clock);
    output_mode_select = 1'b0;
    wt(4, 1, 10, n);
    check(handshake_request, 1'b1);
    output_mode_select = 1'b1;
    wt(4, 0, 4, n);
    wt(4, 1, 10, n);
    check(handshake_request, 1'b1);
    wt(0, 0, 7000, n);
    wt(4, 1, 4, n);
    check({handshake_request, n <= 2}, 2'b11);
    host.rd(1'b1, 1'b0, d, oe);
    check(oe, 8'h00);
    output_mode_select = 1'b0;
    $display("test mode done");
  endtask : t_mode
  // ==========================================================
  // main sequence and watchdog
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    conversion_gate = 1'b1;
    output_mode_select = 1'b0;
    comparator_pos = 1'b0;
    sgn = 1'b1;
    cross_n = 12'h504;
    dcnt = 0;
    zi = 0;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    t_conv;
    t_ovr;
    t_hold;
    t_mode;
    summarize;
  end
  // about three and a half times the expected run length
  initial begin
    #(100000 * 40);
    err_total++;
    summarize;
  end
endmodule : dsa_seq_tb_top
